// File: bench/egress_sink_model.sv
/*
 Far-side model: takes dispatch words and egress slot offers.
 Assumes mclk domain; slow adds random stalls, hold stops the dispatch side.
*/
`timescale 1ns/100ps
`default_nettype none
module egress_sink_model #(parameter int NP = 5) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic hold,
  input wire logic [NP-1:0] egrValid,
  output logic [NP-1:0] egrTake,
  output logic dispReady = 1'b0
);
  logic [NP-1:0] takeMask_r = '0;
  always @(posedge mclk) begin
    takeMask_r <= slow ? NP'($urandom) : '1;
    dispReady <= !reset && !hold && (!slow || $urandom_range(3) == 0);
  end
  // Taking only offered slots frees egress beats so dispatch can go on
  assign egrTake = egrValid & takeMask_r;
endmodule
`default_nettype wire

// File: bench/switch_queue_chk.sv
/*
 Port checker for source_scheduler: slot exclusivity, dispatch stall hold,
 channel limits and register defaults.
 Assumes it is bound into source_scheduler and shares its NP.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sched_defs.svh"
module switch_queue_chk #(parameter int NP = 5) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [NP-1:0] pktValid,
  input wire logic [NP-1:0] pktReady,
  input wire logic [NP-1:0] egrValid,
  input wire logic [NP-1:0] egrVc,
  input wire logic eepromLoad,
  input wire logic eepromLowPrio,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regRdata,
  input wire logic dispValid,
  input wire logic dispReady,
  input wire logic [15:0] dispData
);
  logic written_r;
  logic lowPrio_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Map defaults only hold until software first writes a register
  always_ff @(posedge mclk) begin
    if (reset) written_r <= 1'b0;
    else if (regWrite) written_r <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (reset) lowPrio_r <= 1'b0;
    else if (eepromLoad && eepromLowPrio) lowPrio_r <= 1'b1;
  end
  property p_dispHold;
    dispValid && !dispReady |=> dispValid && $stable(dispData);
  endproperty
  a_dispHold: assert property (p_dispHold) else $error("dispatch word changed while stalled");
  property p_grantFollows;
    (pktValid & pktReady) != '0 |-> ##[1:300] dispValid;
  endproperty
  a_grantFollows: assert property (p_grantFollows) else $error("accepted packet never dispatched");
  property p_oneWriteSlot;
    $onehot0(pktReady);
  endproperty
  a_oneWriteSlot: assert property (p_oneWriteSlot) else $error("two ports in one write slot");
  property p_oneReadSlot;
    $onehot0(egrValid);
  endproperty
  a_oneReadSlot: assert property (p_oneReadSlot) else $error("two ports in one read slot");
  property p_egrNoVc1;
    egrValid[4:3] != 2'b00 |-> (egrVc[4:3] & egrValid[4:3]) == 2'b00;
  endproperty
  a_egrNoVc1: assert property (p_egrNoVc1) else $error("channel 1 on a port without it");
  property p_map0Reset;
    !written_r && !regWrite && regAddr == `OFF_CHAN0_RES_CTL |=> regRdata[7:0] == `RST_TC_MAP0;
  endproperty
  a_map0Reset: assert property (p_map0Reset) else $error("channel 0 map not all ones");
  property p_map1Reset;
    !written_r && !regWrite && regAddr == `OFF_CHAN1_RES_CTL |=> regRdata[7:0] == `RST_TC_MAP1;
  endproperty
  a_map1Reset: assert property (p_map1Reset) else $error("channel 1 map not empty");
  property p_capDefault;
    !lowPrio_r && !regWrite && regAddr == `OFF_CHAN_CAP_ONE |=> !regRdata[`BIT_LOW_PRIO_EXT];
  endproperty
  a_capDefault: assert property (p_capDefault) else $error("equal priority set by default");
  property p_capSet;
    lowPrio_r && !regWrite && regAddr == `OFF_CHAN_CAP_ONE |=> regRdata[`BIT_LOW_PRIO_EXT];
  endproperty
  a_capSet: assert property (p_capSet) else $error("equal priority not loaded");
endmodule
`default_nettype wire

// File: bench/tb_switch_queue_source_scheduler.sv
/*
 Testbench for source_scheduler: register defaults and maps, dispatch
 traffic through the FIFO with a stalling sink.
 Assumes the package and header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sched_defs.svh"
module tb_switch_queue_source_scheduler;
  import sched_pkg::*;
  localparam int NP = 5;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [NP-1:0] pktValid = '0;
  logic [NP*3-1:0] pktDest = '0;
  logic [NP*3-1:0] pktTc = '0;
  logic [NP*2-1:0] pktType = '0;
  logic [NP*8-1:0] pktBeats = '0;
  logic [NP-1:0] pktReady;
  logic [1:0] portWidthLog [NP] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [9:0] inBeatQuota [NP] = '{default: 10'h064};
  logic eepromLoad = 1'b0;
  logic eepromLowPrio = 1'b0;
  logic regWrite = 1'b0;
  logic [2:0] regPort = '0;
  logic [11:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic [31:0] regRdata;
  logic [NP-1:0] egrValid;
  logic [NP-1:0] egrVc;
  logic [NP-1:0] egrTake;
  logic [NP*2-1:0] egrType;
  logic [NP*8-1:0] egrBeats;
  logic dispValid;
  logic dispReady;
  logic [15:0] dispData;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic [15:0] expQ [$];
  int failCount = 0;
  int compares = 0;
  always #2 mclk = ~mclk;
  source_scheduler DUT (.mclk(mclk), .reset(reset), .pktValid(pktValid), .pktDest(pktDest),
    .pktTc(pktTc), .pktType(pktType), .pktBeats(pktBeats), .pktReady(pktReady),
    .portWidthLog(portWidthLog), .inBeatQuota(inBeatQuota), .eepromLoad(eepromLoad),
    .eepromLowPrio(eepromLowPrio), .regWrite(regWrite), .regPort(regPort), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .egrValid(egrValid), .egrType(egrType),
    .egrVc(egrVc), .egrBeats(egrBeats), .egrTake(egrTake), .dispValid(dispValid),
    .dispReady(dispReady), .dispData(dispData));
  egress_sink_model #(.NP(NP)) sink (.mclk(mclk), .reset(reset), .slow(slow), .hold(hold),
    .egrValid(egrValid), .egrTake(egrTake), .dispReady(dispReady));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic regWr(input logic [2:0] p, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regPort <= p;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // Read data is registered, so it is looked at just after the following edge
  task automatic regChk(input logic [2:0] p, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] want);
    @(posedge mclk);
    regPort <= p;
    regAddr <= a;
    @(posedge mclk);
    #1 check(regRdata & m, want);
  endtask
  task automatic send(input int p, input logic [2:0] d, input logic [2:0] tc,
                      input logic [7:0] b, input logic vc);
    int n;
    n = 0;
    @(posedge mclk);
    pktValid[p] <= 1'b1;
    pktDest[p*3+:3] <= d;
    pktTc[p*3+:3] <= tc;
    pktType[p*2+:2] <= 2'(PKT_POSTED);
    pktBeats[p*8+:8] <= b;
    do begin
      @(negedge mclk);
      n++;
    end while (pktReady[p] !== 1'b1 && n < 400);
    @(posedge mclk);
    pktValid[p] <= 1'b0;
    expQ.push_back({d, vc, 2'(PKT_POSTED), b, 2'b00});
    if (n >= 400) failCount++;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) failCount++;
  endtask
  task automatic batch(input int p, input int cnt, input int tcLo, input int dMax,
                       input logic vc);
    repeat (cnt) begin
      send(p, 3'($urandom_range(dMax)), 3'($urandom_range(7, tcLo)),
           8'($urandom_range(14, 1)), vc);
    end
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One packet per handshake, in the order each port handed them in
  always @(negedge mclk) begin
    if (!reset && dispValid === 1'b1 && dispReady === 1'b1) begin
      if (expQ.size() == 0) failCount++;
      else check(32'(dispData), 32'(expQ.pop_front()));
    end
    // Every scenario sends posted packets only, so each taken egress offer must be posted
    for (int e = 0; e < NP; e++) begin
      if (!reset && egrValid[e] === 1'b1 && egrTake[e] === 1'b1) begin
        check(32'(egrType[e*2+:2]), 32'(PKT_POSTED));
      end
    end
  end
  initial begin
    #(60000 * 4);
    failCount++;
    giveVerdict();
  end
  initial begin
    void'($urandom(32'h988F87D7));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    regChk(0, `OFF_CHAN0_RES_CTL, 32'hFF, 32'hFF);
    regChk(3, `OFF_CHAN1_RES_CTL, 32'hFF, 32'h00);
    regChk(0, `OFF_CHAN_CAP_ONE, 32'h10, 32'h00);
    regWr(0, `OFF_CHAN_CAP_ONE, 32'h10);
    regChk(0, `OFF_CHAN_CAP_ONE, 32'h10, 32'h00);
    $display("test register defaults done");
    regWr(0, `OFF_CHAN0_RES_CTL, 32'h01);
    regWr(0, `OFF_CHAN1_RES_CTL, 32'hFE);
    regWr(3, `OFF_CHAN1_RES_CTL, 32'hFE);
    regChk(0, `OFF_CHAN0_RES_CTL, 32'hFF, 32'h01);
    regChk(0, `OFF_CHAN1_RES_CTL, 32'hFF, 32'hFE);
    regChk(3, `OFF_CHAN1_RES_CTL, 32'hFF, 32'h00);
    regChk(1, `OFF_CHAN0_RES_CTL, 32'hFF, 32'hFF);
    $display("test channel maps done");
    slow <= 1'b1;
    batch(0, 12, 1, 2, 1'b1);
    drain();
    batch(1, 12, 0, 4, 1'b0);
    drain();
    batch(3, 12, 0, 4, 1'b0);
    drain();
    $display("test mapped traffic done");
    hold <= 1'b1;
    batch(4, 8, 0, 4, 1'b0);
    repeat (20) @(posedge mclk);
    #1 check(32'(dispValid), 32'h1);
    hold <= 1'b0;
    drain();
    repeat (10) @(posedge mclk);
    #1 check(32'(dispValid), 32'h0);
    $display("test fifo fill and drain done");
    @(posedge mclk);
    eepromLoad <= 1'b1;
    eepromLowPrio <= 1'b1;
    @(posedge mclk);
    eepromLoad <= 1'b0;
    regChk(2, `OFF_CHAN_CAP_ONE, 32'h10, 32'h10);
    $display("test equal priority load done");
    giveVerdict();
  end
endmodule
bind source_scheduler switch_queue_chk #(.NP(NP)) chk (.mclk(mclk), .reset(reset),
  .pktValid(pktValid), .pktReady(pktReady), .egrValid(egrValid), .egrVc(egrVc),
  .eepromLoad(eepromLoad), .eepromLowPrio(eepromLowPrio), .regWrite(regWrite),
  .regAddr(regAddr), .regRdata(regRdata), .dispValid(dispValid), .dispReady(dispReady),
  .dispData(dispData));
`default_nettype wire

// File: logic/dispatch_fifo.sv
/*
 Small dispatch FIFO with valid and ready on both sides.
 Assumes a synchronous active-high reset on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sched_defs.svh"
module dispatch_fifo #(
  parameter int W = 16,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  dispatch_if.dst inQ,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  assign inQ.ready = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inQ.valid && inQ.ready;
  assign pop = outValid && outReady;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inQ.data;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: logic/dispatch_if.sv
/*
 Carrier between the scheduler core and its dispatch FIFO.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface dispatch_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport dst(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: logic/sched_defs.svh
/*
 Shared constants for the switch queue source scheduler: register offsets,
 field positions, reset values and memory sizes.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef SCHED_DEFS_SVH
`define SCHED_DEFS_SVH
`define OFF_CHAN_CAP_ONE 12'h14C
`define OFF_CHAN0_RES_CTL 12'h15C
`define OFF_CHAN1_RES_CTL 12'h168
`define BIT_LOW_PRIO_EXT 4
`define RST_TC_MAP0 8'hFF
`define RST_TC_MAP1 8'h00
`define NUM_PORTS 5
`define BEAT_BYTES 20
`define INGRESS_BEATS 512
`define EGRESS_BEATS 256
`define VOQ_P0 32
`define VOQ_P12 24
`define VOQ_P34 16
`define NUM_QUEUES 6
`define FIFO_DEPTH 4
`endif

// File: logic/sched_pkg.sv
/*
 Types for the source scheduler.
 Assumes sched_defs.svh is on the include path.
*/
`include "sched_defs.svh"
package sched_pkg;
  typedef enum logic [1:0] {PKT_POSTED, PKT_NONPOSTED, PKT_COMPLETION} pkt_type_e;
  typedef logic [2:0] port_t;
  typedef logic [7:0] beat_cnt_t;
  typedef struct packed {
    logic valid;
    port_t dest;
    logic vc;
    pkt_type_e ptype;
    beat_cnt_t beats;
  } voq_entry_s;
endpackage

// File: logic/source_scheduler.sv
/*
 Station queuing and source scheduler: TDM ingress write, VOQ entries,
 oldest-first per-queue selection with round-robin among ingress ports,
 egress beat accounting, TDM egress read and per-port VC arbitration.
 Assumes one clock, packet memory data paths live outside; this block
 keeps descriptors and beat counts only.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sched_defs.svh"
module source_scheduler
  import sched_pkg::*;
#(
  parameter int NP = `NUM_PORTS,
  parameter int BEAT_BYTES = `BEAT_BYTES,
  parameter int IN_BEATS = `INGRESS_BEATS,
  parameter int EG_BEATS = `EGRESS_BEATS,
  parameter logic LOW_PRIO_STRAP = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [NP-1:0] pktValid,
  input wire logic [NP*3-1:0] pktDest,
  input wire logic [NP*3-1:0] pktTc,
  input wire logic [NP*2-1:0] pktType,
  input wire logic [NP*8-1:0] pktBeats,
  output logic [NP-1:0] pktReady,
  input wire logic [1:0] portWidthLog [NP],
  input wire logic [9:0] inBeatQuota [NP],
  input wire logic eepromLoad,
  input wire logic eepromLowPrio,
  input wire logic regWrite,
  input wire logic [2:0] regPort,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic [NP-1:0] egrValid,
  output logic [NP*2-1:0] egrType,
  output logic [NP-1:0] egrVc,
  output logic [NP*8-1:0] egrBeats,
  input wire logic [NP-1:0] egrTake,
  output logic dispValid,
  input wire logic dispReady,
  output logic [15:0] dispData
);
  localparam int VD = `VOQ_P0;
  localparam int QW = $clog2(VD);
  localparam int NQ = `NUM_QUEUES;

  // VOQ depth per port; port index fixes depth
  function automatic int voqDepth(input int p);
    return (p == 0) ? `VOQ_P0 : (p < 3) ? `VOQ_P12 : `VOQ_P34;
  endfunction

  logic [7:0] tcMap0_r [NP];
  logic [7:0] tcMap1_r [NP];
  logic lowPrio_r;
  logic [3:0] tdmSlot_r;
  logic [2:0] slotOwner;
  logic [2:0] rrPtr_r;
  logic [9:0] inUsed_r [NP];
  logic [8:0] egFree_r;
  logic [8:0] egUsed_r [NP];
  logic [7:0] qCount_r [NP][NQ];
  logic [2:0] egRdSlot_r;
  logic [NP-1:0] egLastVc_r;
  voq_entry_s voq_r [NP][VD];
  logic [QW:0] voqCnt_r [NP];
  logic [NP-1:0] portCand;
  logic [QW-1:0] candIdx [NP];
  logic [2:0] grantPort;
  logic grantOk;
  logic [NP-1:0] enq;
  logic [NP-1:0] egrPop;
  voq_entry_s grantEntry;
  dispatch_if #(.W(16)) dq();

  // Slot table: width weight 1,2,4 for x1,x2,x4 out of 16 slots
  always_comb begin
    int acc;
    acc = 0;
    slotOwner = 3'(tdmSlot_r % NP);
    for (int p = 0; p < NP; p++) begin
      if (int'(tdmSlot_r) >= acc && int'(tdmSlot_r) < acc + (1 << portWidthLog[p])) begin
        slotOwner = 3'(p);
      end
      acc = acc + (1 << portWidthLog[p]);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tdmSlot_r <= '0;
    end else begin
      tdmSlot_r <= tdmSlot_r + 4'h1;
    end
  end

  // Registers; equal-priority bit only from LOW_PRIO_STRAP at reset or EEPROM load
  always_ff @(posedge mclk) begin
    if (reset) begin
      lowPrio_r <= LOW_PRIO_STRAP;
      for (int p = 0; p < NP; p++) begin
        tcMap0_r[p] <= `RST_TC_MAP0;
        tcMap1_r[p] <= `RST_TC_MAP1;
      end
    end else begin
      if (eepromLoad) begin
        lowPrio_r <= eepromLowPrio;
      end
      if (regWrite && int'(regPort) < NP) begin
        if (regAddr == `OFF_CHAN0_RES_CTL) begin
          tcMap0_r[regPort] <= {regWdata[7:1], 1'b1};
        end
        if (regAddr == `OFF_CHAN1_RES_CTL && regPort < 3) begin
          tcMap1_r[regPort] <= {regWdata[7:1], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdata <= '0;
    end else if (int'(regPort) < NP) begin
      unique case (regAddr)
        `OFF_CHAN_CAP_ONE: regRdata <= {27'h0, lowPrio_r, 1'b0, 3'(regPort < 3)};
        `OFF_CHAN0_RES_CTL: regRdata <= {24'h800000, tcMap0_r[regPort]};
        `OFF_CHAN1_RES_CTL: regRdata <= {24'h800001, tcMap1_r[regPort]};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // Enqueue one packet per VOQ entry in the port's write slot
  generate
    for (genvar p = 0; p < NP; p++) begin : g_in
      logic [2:0] tc;
      logic vcSel;
      assign tc = pktTc[p*3 +: 3];
      assign vcSel = (p < 3) && tcMap1_r[p][tc] && !tcMap0_r[p][tc];
      assign pktReady[p] = (slotOwner == 3'(p))
        && (int'(voqCnt_r[p]) < voqDepth(p))
        && (int'(inUsed_r[p]) + int'(pktBeats[p*8 +: 8]) <= int'(inBeatQuota[p]))
        && (int'(inBeatQuota[p]) <= IN_BEATS);
      assign enq[p] = pktValid[p] && pktReady[p];
      // Head is entry 0; entries shift so age order is the index order
      always_ff @(posedge mclk) begin
        if (reset) begin
          voqCnt_r[p] <= '0;
          inUsed_r[p] <= '0;
          for (int i = 0; i < VD; i++) begin
            voq_r[p][i] <= '0;
          end
        end else begin
          logic deq;
          logic [QW:0] wpos;
          deq = grantOk && grantPort == 3'(p);
          wpos = voqCnt_r[p];
          if (deq) begin
            for (int i = 0; i < VD; i++) begin
              if (i >= int'(candIdx[p])) begin
                voq_r[p][i] <= (i < VD-1) ? voq_r[p][i+1] : '0;
              end
            end
            wpos = wpos - 1'b1;
          end
          if (enq[p]) begin
            voq_r[p][wpos[QW-1:0]] <= '{1'b1, pktDest[p*3 +: 3], vcSel,
              pkt_type_e'(pktType[p*2 +: 2]), pktBeats[p*8 +: 8]};
          end
          voqCnt_r[p] <= voqCnt_r[p] + (QW+1)'(enq[p]) - (QW+1)'(deq);
          inUsed_r[p] <= inUsed_r[p] + (enq[p] ? 10'(pktBeats[p*8 +: 8]) : 10'h0)
            - (deq ? 10'(grantEntry.beats) : 10'h0);
        end
      end

      // Oldest eligible entry; earlier posted blocks later posted of same channel
      always_comb begin
        logic found;
        logic [1:0] blockP;
        found = 1'b0;
        blockP = 2'b00;
        candIdx[p] = '0;
        for (int i = 0; i < VD; i++) begin
          if (!found && voq_r[p][i].valid) begin
            if (!(voq_r[p][i].ptype == PKT_POSTED && blockP[voq_r[p][i].vc])
                && int'(voq_r[p][i].dest) < NP
                && egFree_r >= 9'(voq_r[p][i].beats)) begin
              found = 1'b1;
              candIdx[p] = QW'(i);
            end else if (voq_r[p][i].ptype == PKT_POSTED) begin
              blockP[voq_r[p][i].vc] = 1'b1;
            end
          end
        end
        portCand[p] = found && dq.ready;
      end
    end
  endgenerate

  // Station-wide grant: channel 1 first unless equal priority, then round robin
  always_comb begin
    logic hiAny;
    logic done;
    int q;
    q = 0;
    hiAny = 1'b0;
    done = 1'b0;
    grantPort = '0;
    for (int p = 0; p < NP; p++) begin
      hiAny = hiAny | (portCand[p] && voq_r[p][candIdx[p]].vc);
    end
    for (int k = 0; k < NP; k++) begin
      q = (int'(rrPtr_r) + k) % NP;
      if (!done && portCand[q] && (lowPrio_r || !hiAny || voq_r[q][candIdx[q]].vc)) begin
        done = 1'b1;
        grantPort = 3'(q);
      end
    end
    grantOk = done;
    grantEntry = voq_r[grantPort][candIdx[grantPort]];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rrPtr_r <= '0;
    end else if (grantOk) begin
      rrPtr_r <= (int'(grantPort) == NP-1) ? 3'h0 : grantPort + 3'h1;
    end
  end

  assign dq.valid = grantOk;
  assign dq.data = {grantEntry.dest, grantEntry.vc, 2'(grantEntry.ptype), grantEntry.beats, 2'b00};

  dispatch_fifo #(.W(16), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .inQ(dq),
    .outValid(dispValid),
    .outReady(dispReady),
    .outData(dispData)
  );

  // Egress beat accounting and channel/type queue counts
  always_ff @(posedge mclk) begin
    if (reset) begin
      egRdSlot_r <= '0;
    end else begin
      egRdSlot_r <= (int'(egRdSlot_r) == NP-1) ? 3'h0 : egRdSlot_r + 3'h1;
    end
  end

  generate
    for (genvar e = 0; e < NP; e++) begin : g_eg
      logic [1:0] tSel [2];
      logic [1:0] hasVc;
      logic pickVc;
      always_comb begin
        hasVc = 2'b00;
        tSel[0] = 2'd0;
        tSel[1] = 2'd0;
        for (int v = 1; v >= 0; v--) begin
          for (int t = 2; t >= 0; t--) begin
            if (qCount_r[e][v*3+t] != 8'h0) begin
              hasVc[v] = 1'b1;
              tSel[v] = 2'(t);
            end
          end
        end
        // Strict priority or alternating when equal priority
        pickVc = hasVc[1] && (!lowPrio_r || !hasVc[0] || !egLastVc_r[e]);
      end
      assign egrValid[e] = (egRdSlot_r == 3'(e)) && (hasVc != 2'b00);
      assign egrVc[e] = pickVc;
      assign egrType[e*2 +: 2] = tSel[pickVc];
      assign egrBeats[e*8 +: 8] = 8'(egUsed_r[e]);
      assign egrPop[e] = egrValid[e] && egrTake[e];
      always_ff @(posedge mclk) begin
        if (reset) begin
          egLastVc_r[e] <= 1'b0;
          for (int i = 0; i < NQ; i++) begin
            qCount_r[e][i] <= '0;
          end
        end else begin
          if (egrPop[e]) begin
            egLastVc_r[e] <= pickVc;
          end
          for (int i = 0; i < NQ; i++) begin
            qCount_r[e][i] <= qCount_r[e][i]
              + 8'(dispValid && dispReady && int'(dispData[15:13]) == e
                   && int'(dispData[12] && e < 3) * 3 + int'(dispData[11:10]) == i)
              - 8'(egrPop[e] && int'(pickVc) * 3 + int'(tSel[pickVc]) == i);
          end
        end
      end
    end
  endgenerate

  // Space is reserved on grant, returned when the egress port takes a packet
  always_ff @(posedge mclk) begin
    if (reset) begin
      egFree_r <= 9'(EG_BEATS);
      for (int e = 0; e < NP; e++) begin
        egUsed_r[e] <= '0;
      end
    end else begin
      logic [8:0] back;
      back = '0;
      for (int e = 0; e < NP; e++) begin
        if (egrPop[e]) begin
          back = 9'(egUsed_r[e]);
        end
        if (dispValid && dispReady && int'(dispData[15:13]) == e) begin
          egUsed_r[e] <= 9'(dispData[9:2]);
        end
      end
      egFree_r <= egFree_r - (grantOk && dq.ready ? 9'(grantEntry.beats) : 9'h0) + back;
    end
  end
endmodule
`default_nettype wire
